// *** hdl/pio_io_decoder.sv ***
`timescale 1ns/1ps
// Operation
// - fourteen module addresses, 2 to F, decoded from the 4-bit address of each access.
// - plain access with no switch selection hits the primary register.
// - writing a module address to the switch makes its next access auxiliary.
// - byte registers move as two successive nibble accesses to one address.
// - timer address holds up to sixteen subports chosen by an index.
// - first write loads subport index, next access moves subport data.
// - subports 0-5 timer two, 8-A timer one and watchdog, rest reserved.
// - port data at 2, 4, 5 writable, reads pin state, reset ones.
// - address 3 write sets configuration, read restarts the watchdog.
// - auxiliary at 3 is write-only clock management, reset ones.
// - port 4 and 5 auxiliary controls are byte wide, reset ones.
// - switch register at address 8 is write-only, reset ones.
// - serial address byte write loads transmit, byte read returns receive.
// - serial status/control at A read-write, auxiliary control two resets ones.
// - rom bank select at D is write-only, resets to zero.
// - address F writes monitor control, reads monitor status reset xx11.
// - subport 5 compare register is a byte of two nibbles, reset ones.
module pio_io_decoder
    import pio_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic  [3:0] i_io_addr,
    input  wire logic  [3:0] i_io_wdata,
    output logic       [3:0] o_io_rdata,
    output logic             o_io_rvalid,
    input  wire logic [11:0] i_pin,
    output logic      [11:0] o_pin_out,
    output logic      [11:0] o_pin_oe,
    input  wire logic  [7:0] i_serial_rx,
    input  wire logic  [3:0] i_serial_status,
    input  wire logic  [3:0] i_vmon_status,
    output logic       [3:0] o_system_configuration,
    output logic       [3:0] o_clock_management,
    output logic             o_clock_sync,
    output logic             o_watchdog_restart,
    output logic       [3:0] o_port2_direction,
    output logic       [7:0] o_port4_control,
    output logic       [7:0] o_port5_control,
    output logic       [7:0] o_serial_tx_buffer,
    output logic             o_serial_tx_load,
    output logic             o_serial_rx_taken,
    output logic       [3:0] o_serial_control_one,
    output logic       [3:0] o_serial_status_control,
    output logic       [3:0] o_serial_control_two,
    output logic       [3:0] o_rom_bank_select,
    output logic       [3:0] o_voltage_monitor_control,
    output logic       [3:0] o_aux_select_switch,
    output logic      [63:0] o_subport_nibbles,
    output logic       [7:0] o_timer2_compare_two
);
    typedef enum logic {SP_IDLE, SP_INDEX} pio_sub_e;

    pio_sub_e    sp_state_r;
    pio_sub_e    sp_state_nxt;
    logic  [3:0] subport_index_r;
    logic        aux_valid_r;
    logic        aux_valid_nxt;
    logic  [3:0] vmon_status_r;
    logic        half;
    logic  [3:0] low_nib;
    logic  [3:0] rdata_nxt;
    logic  [3:0] port_wdata [NUM_PORTS];
    logic  [3:0] port_data  [NUM_PORTS];
    logic  [3:0] port_oe    [NUM_PORTS];
    logic  [3:0] port_drive [NUM_PORTS];
    logic        port_wr    [NUM_PORTS];

    wire         acc = i_io_wr | i_io_rd;
    wire         a_p2  = (i_io_addr == ADDR_PORT2);
    wire         a_sc  = (i_io_addr == ADDR_SYSCFG);
    wire         a_p4  = (i_io_addr == ADDR_PORT4);
    wire         a_p5  = (i_io_addr == ADDR_PORT5);
    wire         a_tm  = (i_io_addr == ADDR_TIMER);
    wire         a_sw  = (i_io_addr == ADDR_AUXSW);
    wire         a_ser = (i_io_addr == ADDR_SERIAL);
    wire         a_ss  = (i_io_addr == ADDR_SERSTAT);
    wire         a_rb  = (i_io_addr == ADDR_ROMBANK);
    wire         a_vm  = (i_io_addr == ADDR_VMON);

    // auxiliary only for the address held in the switch
    wire         aux_sel = aux_valid_r & (i_io_addr == o_aux_select_switch);
    wire         prim_wr = i_io_wr & ~aux_sel;
    wire         prim_rd = i_io_rd & ~aux_sel;
    wire         aux_wr  = i_io_wr & aux_sel;

    // data phase follows an index load
    wire         sp_data = a_tm & (sp_state_r == SP_INDEX);
    wire         sp_byte = sp_data & (subport_index_r == SUB_T2_CMP2);

    // byte targets advance the shared nibble sequencer
    wire         byte_wr = (aux_wr & (a_p4 | a_p5)) | (prim_wr & a_ser)
                         | (i_io_wr & sp_byte);
    wire         byte_rd = (prim_rd & a_ser) | (i_io_rd & sp_byte);
    wire         byte_step = byte_wr | byte_rd;
    wire         byte_done = byte_step & half;

    // switch register is always primary at its own address
    wire         w_sw    = i_io_wr & a_sw;
    // configuration write, watchdog restart on read
    wire         w_sc    = prim_wr & a_sc;
    wire         r_wdt   = prim_rd & a_sc;
    wire         w_cm    = aux_wr & a_sc;
    wire         w_port2_direction  = aux_wr & a_p2;
    // port controls commit on the second nibble
    wire         w_port4_control  = aux_wr & a_p4 & half;
    wire         w_port5_control  = aux_wr & a_p5 & half;
    wire         w_stb   = prim_wr & a_ser & half;
    wire         r_srb   = prim_rd & a_ser & half;
    wire         w_serial_control_one  = aux_wr & a_ser;
    wire         w_serial_status_control  = prim_wr & a_ss;
    wire         w_serial_control_two  = aux_wr & a_ss;
    wire         w_rbr   = i_io_wr & a_rb;
    wire         w_vmc   = i_io_wr & a_vm;
    // compare byte commits on its high nibble
    wire         w_cmp2  = i_io_wr & sp_byte & half;

    // selection ends once the selected access completes
    wire         aux_used = acc & aux_sel & ~(byte_step & ~half);
    // a new selection in the same cycle wins over the clear
    assign aux_valid_nxt = w_sw ? 1'b1 : (aux_used ? 1'b0 : aux_valid_r);

    // index load and data phase walk
    always_comb
    begin
        sp_state_nxt = sp_state_r;
        case (sp_state_r)
            SP_IDLE:
            begin
                if (i_io_wr && a_tm)
                begin
                    sp_state_nxt = SP_INDEX;
                end
            end
            SP_INDEX:
            begin
                if (acc && !a_tm)
                begin
                    // foreign access abandons the indirect pair
                    sp_state_nxt = SP_IDLE;
                end
                else if (acc && !(sp_byte && !half))
                begin
                    sp_state_nxt = SP_IDLE;
                end
            end
            default:
            begin
                sp_state_nxt = SP_IDLE;
            end
        endcase
    end

    pio_nibble_pair u_pair
    (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_access (acc),
        .i_step   (byte_step),
        .i_nib    (i_io_wdata),
        .o_half   (half),
        .o_low    (low_nib)
    );

    // port 4/5 pins drive where their mode code says output
    assign port_drive[0] = ~o_port2_direction;
    assign port_wr[0]    = prim_wr & a_p2;
    assign port_wr[1]    = prim_wr & a_p4;
    assign port_wr[2]    = prim_wr & a_p5;

    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            assign port_wdata[gp] = i_io_wdata;
            assign o_pin_out[4*gp+3 -: 4] = port_data[gp];
            assign o_pin_oe[4*gp+3 -: 4]  = port_oe[gp];
            pio_port u_port
            (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_wr    (port_wr[gp]),
                .i_wdata (port_wdata[gp]),
                .i_drive (port_drive[gp]),
                .o_data  (port_data[gp]),
                .o_oe    (port_oe[gp])
            );
        end
        for (gb = 0; gb < 4; gb++)
        begin : g_mode
            assign port_drive[1][gb] = (o_port4_control[2*gb+1 -: 2] == MODE_OUTPUT);
            assign port_drive[2][gb] = (o_port5_control[2*gb+1 -: 2] == MODE_OUTPUT);
        end
    endgenerate

    // nibble subports; reserved indices keep no state
    genvar gs;
    generate
        for (gs = 0; gs < 16; gs++)
        begin : g_sub
            if (SUB_NIB_MASK[gs])
            begin : g_live
                wire w_sub = i_io_wr & sp_data & (subport_index_r == 4'(gs));
                always_ff @(posedge i_clk or posedge i_rst)
                begin
                    if (i_rst)
                    begin
                        o_subport_nibbles[4*gs+3 -: 4] <= SUB_RST[4*gs+3 -: 4];
                    end
                    else if (w_sub)
                    begin
                        o_subport_nibbles[4*gs+3 -: 4] <= i_io_wdata;
                    end
                end
            end
            else
            begin : g_rsv
                assign o_subport_nibbles[4*gs+3 -: 4] = RST_ZERO_NIB;
            end
        end
    endgenerate

    // high nibble on first read, low on second
    wire   [3:0] cmp2_rd = half ? o_timer2_compare_two[3:0] : o_timer2_compare_two[7:4];
    wire   [3:0] srb_rd  = half ? i_serial_rx[3:0] : i_serial_rx[7:4];

    // reserved addresses and write-only targets read zero
    always_comb
    begin
        rdata_nxt = RST_ZERO_NIB;
        case (i_io_addr)
            ADDR_PORT2:   rdata_nxt = prim_rd ? i_pin[3:0]  : RST_ZERO_NIB;
            ADDR_PORT4:   rdata_nxt = prim_rd ? i_pin[7:4]  : RST_ZERO_NIB;
            ADDR_PORT5:   rdata_nxt = prim_rd ? i_pin[11:8] : RST_ZERO_NIB;
            ADDR_TIMER:   rdata_nxt = sp_byte ? cmp2_rd : RST_ZERO_NIB;
            ADDR_SERIAL:  rdata_nxt = prim_rd ? srb_rd : RST_ZERO_NIB;
            ADDR_SERSTAT: rdata_nxt = prim_rd ? i_serial_status : RST_ZERO_NIB;
            ADDR_VMON:    rdata_nxt = vmon_status_r;
            default:      rdata_nxt = RST_ZERO_NIB;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sp_state_r      <= SP_IDLE;
            subport_index_r <= RST_ZERO_NIB;
            aux_valid_r     <= 1'b0;
            vmon_status_r   <= RST_VMSTAT;
            o_io_rdata      <= RST_ZERO_NIB;
            o_io_rvalid     <= 1'b0;
        end
        else
        begin
            sp_state_r  <= sp_state_nxt;
            aux_valid_r <= aux_valid_nxt;
            if (i_io_wr && a_tm && sp_state_r == SP_IDLE)
            begin
                subport_index_r <= i_io_wdata;
            end
            vmon_status_r <= i_vmon_status;
            o_io_rvalid   <= i_io_rd;
            if (i_io_rd)
            begin
                o_io_rdata <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_clock_sync       <= 1'b0;
            o_watchdog_restart <= 1'b0;
            o_serial_tx_load   <= 1'b0;
            o_serial_rx_taken  <= 1'b0;
        end
        else
        begin
            o_clock_sync       <= w_cm;
            o_watchdog_restart <= r_wdt;
            o_serial_tx_load   <= w_stb;
            o_serial_rx_taken  <= r_srb;
        end
    end

    // nibble registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_aux_select_switch       <= RST_NIB_ONES;
            o_system_configuration    <= RST_SYSCFG;
            o_clock_management        <= RST_NIB_ONES;
            o_port2_direction         <= RST_NIB_ONES;
            o_serial_control_one      <= RST_NIB_ONES;
            o_serial_status_control   <= RST_SERSTAT;
            o_serial_control_two      <= RST_NIB_ONES;
            o_rom_bank_select         <= RST_ROMBANK;
            o_voltage_monitor_control <= RST_NIB_ONES;
        end
        else
        begin
            if (w_sw)   o_aux_select_switch       <= i_io_wdata;
            if (w_sc)   o_system_configuration    <= i_io_wdata;
            if (w_cm)   o_clock_management        <= i_io_wdata;
            if (w_port2_direction) o_port2_direction         <= i_io_wdata;
            if (w_serial_control_one) o_serial_control_one      <= i_io_wdata;
            if (w_serial_status_control) o_serial_status_control   <= i_io_wdata;
            if (w_serial_control_two) o_serial_control_two      <= i_io_wdata;
            if (w_rbr)  o_rom_bank_select         <= i_io_wdata;
            if (w_vmc)  o_voltage_monitor_control <= i_io_wdata;
        end
    end

    // byte registers, high nibble arrives second
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_port4_control      <= RST_BYTE_ONES;
            o_port5_control      <= RST_BYTE_ONES;
            o_serial_tx_buffer   <= RST_ZERO_BYTE;
            o_timer2_compare_two <= RST_BYTE_ONES;
        end
        else
        begin
            // low nibble was held from the first write
            if (w_port4_control) o_port4_control      <= {i_io_wdata, low_nib};
            if (w_port5_control) o_port5_control      <= {i_io_wdata, low_nib};
            if (w_stb)  o_serial_tx_buffer   <= {i_io_wdata, low_nib};
            if (w_cmp2) o_timer2_compare_two <= {i_io_wdata, low_nib};
        end
    end
endmodule : pio_io_decoder

// *** hdl/pio_pkg.sv ***
package pio_pkg;
    // module addresses on the i/o bus
    localparam logic [3:0] ADDR_PORT2    = 4'h2;
    localparam logic [3:0] ADDR_SYSCFG   = 4'h3;
    localparam logic [3:0] ADDR_PORT4    = 4'h4;
    localparam logic [3:0] ADDR_PORT5    = 4'h5;
    localparam logic [3:0] ADDR_RSV6     = 4'h6;
    localparam logic [3:0] ADDR_TIMER    = 4'h7;
    localparam logic [3:0] ADDR_AUXSW    = 4'h8;
    localparam logic [3:0] ADDR_SERIAL   = 4'h9;
    localparam logic [3:0] ADDR_SERSTAT  = 4'hA;
    localparam logic [3:0] ADDR_RSVB     = 4'hB;
    localparam logic [3:0] ADDR_RSVC     = 4'hC;
    localparam logic [3:0] ADDR_ROMBANK  = 4'hD;
    localparam logic [3:0] ADDR_RSVE     = 4'hE;
    localparam logic [3:0] ADDR_VMON     = 4'hF;

    // subport indices behind the timer address
    localparam logic [3:0] SUB_T2_CTRL   = 4'h0;
    localparam logic [3:0] SUB_T2_MODE1  = 4'h1;
    localparam logic [3:0] SUB_T2_MODE2  = 4'h2;
    localparam logic [3:0] SUB_T2_CMODE  = 4'h3;
    localparam logic [3:0] SUB_T2_CMP1   = 4'h4;
    localparam logic [3:0] SUB_T2_CMP2   = 4'h5;
    localparam logic [3:0] SUB_T1_CTRL1  = 4'h8;
    localparam logic [3:0] SUB_T1_CTRL2  = 4'h9;
    localparam logic [3:0] SUB_WDOG_CTRL = 4'hA;
    // nibble subports that exist: 0-4, 8, 9, A (5 is the byte one)
    localparam logic [15:0] SUB_NIB_MASK = 16'h071F;
    // reset nibbles indexed by subport, entry i at bits 4i+3..4i
    localparam logic [63:0] SUB_RST      = 64'h0000_0F7F_000F_0FF0;

    // reset values
    localparam logic [3:0] RST_NIB_ONES  = 4'hF;
    localparam logic [7:0] RST_BYTE_ONES = 8'hFF;
    localparam logic [3:0] RST_SYSCFG    = 4'hB;
    localparam logic [3:0] RST_SERSTAT   = 4'hB;
    localparam logic [3:0] RST_ROMBANK   = 4'h0;
    localparam logic [3:0] RST_VMSTAT    = 4'h3;
    localparam logic [3:0] RST_ZERO_NIB  = 4'h0;
    localparam logic [7:0] RST_ZERO_BYTE = 8'h00;

    // port mode code meaning output drive
    localparam logic [1:0] MODE_OUTPUT   = 2'b00;
    localparam int         NUM_PORTS     = 3;
endpackage : pio_pkg

// *** hdl/pio_nibble_pair.sv ***
`timescale 1ns/1ps
module pio_nibble_pair
    import pio_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_access,
    input  wire logic       i_step,
    input  wire logic [3:0] i_nib,
    output logic            o_half,
    output logic      [3:0] o_low
);
    logic half_nxt;

    // any other access breaks off a half-done byte
    assign half_nxt = i_step ? ~o_half : (i_access ? 1'b0 : o_half);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_half <= 1'b0;
            o_low  <= RST_ZERO_NIB;
        end
        else
        begin
            o_half <= half_nxt;
            if (i_step && !o_half)
            begin
                o_low <= i_nib;
            end
        end
    end
endmodule : pio_nibble_pair

// *** hdl/pio_port.sv ***
`timescale 1ns/1ps
module pio_port
    import pio_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic [3:0] i_wdata,
    input  wire logic [3:0] i_drive,
    output logic      [3:0] o_data,
    output logic      [3:0] o_oe
);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_data <= RST_NIB_ONES;
            o_oe   <= RST_ZERO_NIB;
        end
        else
        begin
            if (i_wr)
            begin
                o_data <= i_wdata;
            end
            // oe lags its control write by one cycle
            o_oe <= i_drive;
        end
    end
endmodule : pio_port

// *** bench/pio_pad_model.sv ***
`timescale 1ns/1ps
// pin pads: design drives where enabled, the outside source elsewhere
module pio_pad_model
(
    input  wire logic [11:0] i_out,
    input  wire logic [11:0] i_oe,
    input  wire logic [11:0] i_ext,
    output logic      [11:0] o_pin
);
    assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule : pio_pad_model

// *** bench/pio_io_decoder_sva.sv ***
`timescale 1ns/1ps
module pio_io_decoder_sva
    import pio_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_io_wr,
    input wire logic        i_io_rd,
    input wire logic  [3:0] i_io_addr,
    input wire logic  [3:0] i_io_wdata,
    input wire logic  [3:0] i_vmon_status,
    input wire logic  [3:0] o_io_rdata,
    input wire logic        o_io_rvalid,
    input wire logic [11:0] o_pin_oe,
    input wire logic        o_watchdog_restart,
    input wire logic  [3:0] o_port2_direction,
    input wire logic  [7:0] o_port4_control,
    input wire logic        o_serial_tx_load,
    input wire logic  [3:0] o_rom_bank_select,
    input wire logic  [3:0] o_voltage_monitor_control,
    input wire logic  [3:0] o_aux_select_switch
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire  rsv_rd = i_io_rd && (i_io_addr == ADDR_RSV6 || i_io_addr == ADDR_RSVB
                   || i_io_addr == ADDR_RSVC || i_io_addr == ADDR_RSVE);
    wire  wr_at  = i_io_wr;
    wire  p4_out = o_port4_control[1:0] == MODE_OUTPUT;
    a_read_answer: assert property (i_io_rd |=> o_io_rvalid)
        else $error("read got no answer");
    a_answer_cause: assert property (o_io_rvalid |-> $past(i_io_rd))
        else $error("answer without read");
    a_reserved_zero: assert property (rsv_rd |=> o_io_rdata == 4'h0)
        else $error("reserved read not zero");
    a_wdt_cause: assert property (o_watchdog_restart |->
        $past(i_io_rd) && $past(i_io_addr) == ADDR_SYSCFG) else $error("stray restart");
    a_switch_load: assert property (wr_at && i_io_addr == ADDR_AUXSW
        |=> o_aux_select_switch == $past(i_io_wdata)) else $error("switch not loaded");
    a_rom_load: assert property (wr_at && i_io_addr == ADDR_ROMBANK
        |=> o_rom_bank_select == $past(i_io_wdata)) else $error("bank not loaded");
    a_vmc_load: assert property (wr_at && i_io_addr == ADDR_VMON
        |=> o_voltage_monitor_control == $past(i_io_wdata)) else $error("vmc not loaded");
    a_voltage_monitor_status_read: assert property (i_io_rd && i_io_addr == ADDR_VMON && !$past(i_rst)
        |=> o_io_rdata == $past(i_vmon_status, 2)) else $error("status read wrong");
    a_txload_cause: assert property (o_serial_tx_load |->
        $past(i_io_wr) && $past(i_io_addr) == ADDR_SERIAL) else $error("stray tx load");
    a_p2_drive: assert property (o_pin_oe[3:0] == ~$past(o_port2_direction))
        else $error("port2 enable wrong");
    a_p4_drive: assert property (o_pin_oe[4] == $past(p4_out))
        else $error("port4 enable wrong");
    c_restart: cover property (o_watchdog_restart);
    c_tx_load: cover property (o_serial_tx_load);
    c_reserved: cover property (rsv_rd);
endmodule : pio_io_decoder_sva
bind pio_io_decoder pio_io_decoder_sva pio_io_decoder_sva_i (.i_clk, .i_rst, .i_io_wr,
    .i_io_rd, .i_io_addr, .i_io_wdata, .i_vmon_status, .o_io_rdata, .o_io_rvalid,
    .o_pin_oe, .o_watchdog_restart, .o_port2_direction, .o_port4_control,
    .o_serial_tx_load, .o_rom_bank_select, .o_voltage_monitor_control,
    .o_aux_select_switch);

// *** bench/pio_io_decoder_bench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pio_io_decoder_bench;
    import pio_pkg::*;
    logic        i_clk, i_rst, i_io_wr, i_io_rd;
    logic  [3:0] i_io_addr, i_io_wdata, i_serial_status, i_vmon_status, d;
    logic  [7:0] i_serial_rx;
    logic [11:0] ext;
    wire  [11:0] i_pin, o_pin_out, o_pin_oe;
    wire         o_io_rvalid, o_clock_sync, o_watchdog_restart;
    wire         o_serial_tx_load, o_serial_rx_taken;
    wire   [3:0] o_io_rdata, o_system_configuration, o_clock_management;
    wire   [3:0] o_port2_direction, o_serial_control_one, o_serial_status_control;
    wire   [3:0] o_serial_control_two, o_rom_bank_select, o_voltage_monitor_control;
    wire   [3:0] o_aux_select_switch;
    wire   [7:0] o_port4_control, o_port5_control, o_serial_tx_buffer;
    wire   [7:0] o_timer2_compare_two;
    wire  [63:0] o_subport_nibbles;
    int          fails = 0;
    int          n_checks = 0;
    pio_io_decoder pio_io_decoder_i (.i_clk, .i_rst, .i_io_wr, .i_io_rd, .i_io_addr,
        .i_io_wdata, .o_io_rdata, .o_io_rvalid, .i_pin, .o_pin_out, .o_pin_oe,
        .i_serial_rx, .i_serial_status, .i_vmon_status, .o_system_configuration,
        .o_clock_management, .o_clock_sync, .o_watchdog_restart, .o_port2_direction,
        .o_port4_control, .o_port5_control, .o_serial_tx_buffer, .o_serial_tx_load,
        .o_serial_rx_taken, .o_serial_control_one, .o_serial_status_control,
        .o_serial_control_two, .o_rom_bank_select, .o_voltage_monitor_control,
        .o_aux_select_switch, .o_subport_nibbles, .o_timer2_compare_two);
    pio_pad_model pio_pad_model_i (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_ext(ext),
        .o_pin(i_pin));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [3:0] v);
        @(posedge i_clk);
        #1;
        i_io_addr = a;
        i_io_wdata = v;
        i_io_wr = 1'b1;
        @(posedge i_clk);
        #1;
        i_io_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        #1;
        i_io_addr = a;
        i_io_rd = 1'b1;
        @(posedge i_clk);
        #1;
        i_io_rd = 1'b0;
        d = o_io_rdata;
        `CHK(o_io_rvalid, 1'b1)
    endtask : rd
    task automatic t_reset;
        `CHK(o_aux_select_switch, 4'hF)
        `CHK(o_clock_management, 4'hF)
        `CHK(o_system_configuration & 4'hB, 4'hB)
        `CHK(o_pin_out, 12'hFFF)
        `CHK({o_port4_control, o_port5_control}, 16'hFFFF)
        `CHK(o_serial_control_two, 4'hF)
        `CHK(o_rom_bank_select, 4'h0)
        `CHK(o_voltage_monitor_control, 4'hF)
        `CHK(o_timer2_compare_two, 8'hFF)
        `CHK(o_subport_nibbles, 64'h0000_0F7F_000F_0FF0)
        rd(ADDR_VMON);
        `CHK(d, 4'h3)
        $display("test reset done");
    endtask : t_reset
    task automatic t_port;
        wr(ADDR_PORT2, 4'hA);
        `CHK(o_pin_out[3:0], 4'hA)
        rd(ADDR_PORT2);
        `CHK(d, 4'h5)
        wr(ADDR_AUXSW, ADDR_PORT2);
        wr(ADDR_PORT2, 4'h0);
        `CHK({o_port2_direction, o_pin_out[3:0]}, 8'h0A)
        wr(ADDR_PORT2, 4'h6);
        `CHK({o_port2_direction, o_pin_out[3:0]}, 8'h06)
        `CHK(o_pin_oe[3:0], 4'hF)
        rd(ADDR_PORT2);
        `CHK(d, 4'h6)
        $display("test port done");
    endtask : t_port
    task automatic t_byte;
        wr(ADDR_AUXSW, ADDR_PORT4);
        wr(ADDR_PORT4, 4'h0);
        `CHK(o_port4_control, 8'hFF)
        wr(ADDR_PORT4, 4'hF);
        `CHK(o_port4_control, 8'hF0)
        @(posedge i_clk);
        #1;
        `CHK(o_pin_oe[7:4], 4'h3)
        wr(ADDR_PORT4, 4'h9);
        `CHK({o_port4_control, o_pin_out[7:4]}, 12'hF09)
        wr(ADDR_AUXSW, ADDR_PORT5);
        wr(ADDR_PORT5, 4'h3);
        wr(ADDR_PORT5, 4'hC);
        `CHK(o_port5_control, 8'hC3)
        @(posedge i_clk);
        #1;
        `CHK(o_pin_oe[11:8], 4'h6)
        $display("test byte done");
    endtask : t_byte
    task automatic t_sub;
        logic [3:0]  idx [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA};
        logic [63:0] exp = 64'h0000_0F7F_000F_0FF0;
        foreach (idx[k])
        begin
            wr(ADDR_TIMER, idx[k]);
            wr(ADDR_TIMER, idx[k] ^ 4'h5);
            exp[4 * idx[k] +: 4] = idx[k] ^ 4'h5;
            `CHK(o_subport_nibbles, exp)
        end
        wr(ADDR_TIMER, 4'h6);
        wr(ADDR_TIMER, 4'h9);
        wr(ADDR_TIMER, 4'hB);
        wr(ADDR_TIMER, 4'h9);
        `CHK(o_subport_nibbles, exp)
        wr(ADDR_TIMER, SUB_T2_CMP2);
        wr(ADDR_TIMER, 4'h2);
        wr(ADDR_TIMER, 4'hD);
        `CHK(o_timer2_compare_two, 8'hD2)
        wr(ADDR_TIMER, SUB_T2_CMP2);
        rd(ADDR_TIMER);
        `CHK(d, 4'hD)
        rd(ADDR_TIMER);
        `CHK(d, 4'h2)
        $display("test subport done");
    endtask : t_sub
    task automatic t_serial;
        wr(ADDR_SERIAL, 4'h1);
        wr(ADDR_SERIAL, 4'h7);
        `CHK({o_serial_tx_buffer, o_serial_tx_load}, 9'h0E3)
        rd(ADDR_SERIAL);
        `CHK(d, 4'h3)
        rd(ADDR_SERIAL);
        `CHK({d, o_serial_rx_taken}, 5'h19)
        wr(ADDR_AUXSW, ADDR_SERIAL);
        wr(ADDR_SERIAL, 4'h4);
        `CHK(o_serial_control_one, 4'h4)
        wr(ADDR_SERSTAT, 4'h2);
        rd(ADDR_SERSTAT);
        `CHK({d, o_serial_status_control}, 8'h62)
        wr(ADDR_AUXSW, ADDR_SERSTAT);
        wr(ADDR_SERSTAT, 4'h5);
        `CHK({o_serial_control_two, o_serial_status_control}, 8'h52)
        $display("test serial done");
    endtask : t_serial
    task automatic t_misc;
        logic [3:0] rsv [4] = '{ADDR_RSV6, ADDR_RSVB, ADDR_RSVC, ADDR_RSVE};
        wr(ADDR_SYSCFG, 4'h1);
        rd(ADDR_SYSCFG);
        `CHK({o_system_configuration, d, o_watchdog_restart}, 9'h021)
        wr(ADDR_AUXSW, ADDR_SYSCFG);
        wr(ADDR_SYSCFG, 4'h6);
        `CHK({o_clock_management, o_clock_sync, o_system_configuration}, 9'h0D1)
        wr(ADDR_ROMBANK, 4'h9);
        wr(ADDR_VMON, 4'h2);
        i_vmon_status = 4'hE;
        rd(ADDR_VMON);
        `CHK({o_rom_bank_select, o_voltage_monitor_control, d}, 12'h92E)
        foreach (rsv[k])
        begin
            wr(rsv[k], 4'h0);
            rd(rsv[k]);
            `CHK(d, 4'h0)
        end
        `CHK({o_rom_bank_select, o_aux_select_switch, o_pin_out}, 20'h93F96)
        $display("test misc done");
    endtask : t_misc
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        #50000;
        fails++;
        wrap_up();
    end
    initial
    begin
        {i_io_wr, i_io_rd, i_io_addr, i_io_wdata} = '0;
        {i_serial_rx, i_serial_status, i_vmon_status, ext} = {8'h3C, 4'h6, 4'h3, 12'h5A5};
        i_rst = 1'b1;
        repeat (10) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_reset();
        t_port();
        t_byte();
        t_sub();
        t_serial();
        t_misc();
        wrap_up();
    end
endmodule : pio_io_decoder_bench
